// File: rtl/cpw_pkg.sv
/*
 Constants for the chain power-mode and wake-up sequencer.
 Assumes a 100 MHz core clock; all times derive counts from it.
*/
package cpw_pkg;
    localparam int CLK_MHZ          = 100;
    localparam int CLK_PERIOD_NS    = 10;
    localparam int RST_PULSE_MIN_NS = 100;
    localparam int SPI_READY_US     = 200;
    localparam int ACC_READY_MS     = 5;
    localparam int WAKE_FWD_US      = 100;
    // Least time rounds up to whole cycles
    localparam int RST_PULSE_CYC =
        (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPI_READY_CYC = SPI_READY_US * CLK_MHZ;
    localparam int ACC_READY_CYC = ACC_READY_MS * 1000 * CLK_MHZ;
    localparam int WAKE_FWD_CYC  = WAKE_FWD_US * CLK_MHZ;
    localparam int CNT_W         = 24;
    localparam int PULSE_W       = 8;
    localparam int SETTLE_W      = 3;
    // Edges after reset wait until the pin has passed the synchroniser
    localparam int SYNC_SETTLE_CYC = 6;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;

    typedef enum logic [1:0] {
        CPW_MODE_FULL_PD,
        CPW_MODE_ACTIVE,
        CPW_MODE_PART_PD
    } cpw_mode_t;
endpackage : cpw_pkg

// File: rtl/cpw_seq.sv
/*
 Power-mode and wake-up sequencer of one chained battery monitor.
 Assumes pins are asynchronous; software mode requests and the
 power-down timer status come from logic on i_clk.
*/
// How it works
// - Rising interface supply starts master power-up
// - Reset pulse of 100 ns powers up master
// - Serial access ready 200 us after start
// - Conversions accurate 5 ms after start
// - Wake forwarded to next device up chain
// - Forward wake within 100 us of receipt
// - Slave conversions accurate 5 ms after wake
// - Supply low on the master enters full power-down unless timer
// - Exactly three modes: active, partial, full
// - Active permits conversions, readback, registers, balancing
// - Partial power-down keeps registers and balancing
// - Power-down timer defers shutdown while balancing
`timescale 1ns/1ps
module cpw_seq #(
    parameter int SPI_CYC  = cpw_pkg::SPI_READY_CYC,
    parameter int ACC_CYC  = cpw_pkg::ACC_READY_CYC,
    parameter int FWD_CYC  = cpw_pkg::WAKE_FWD_CYC
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // Role strap: high for the master, low for a slave
    input  wire logic              i_is_master,
    // Pins
    input  wire logic              i_vdrive,
    input  wire logic              i_reset_pin,
    input  wire logic              i_wake_in,
    // Software and timer status
    input  wire logic              i_sw_part_pd,
    input  wire logic              i_sw_wake,
    input  wire logic              i_pd_timer_run,
    // Status
    output cpw_pkg::cpw_mode_t     o_mode,
    output logic                   o_spi_ready,
    output logic                   o_conv_ready,
    output logic                   o_wake_out,
    // Permissions
    output logic                   o_conv_en,
    output logic                   o_reg_en,
    output logic                   o_bal_en
);
    import cpw_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic vd_s;
    logic rst_s;
    logic wk_s;

    cpw_sync u_vd (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pin(i_vdrive),
                   .o_level(vd_s));
    cpw_sync u_rs (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pin(i_reset_pin),
                   .o_level(rst_s));
    cpw_sync u_wk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pin(i_wake_in),
                   .o_level(wk_s));

    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        dec_sat = (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
    endfunction : dec_sat

    ////////////////////////////////////////////////////////////////////
    logic              vd_d_r;
    logic              rs_d_r;
    logic              wk_d_r;
    logic [PULSE_W-1:0] rs_len_r;
    logic              rs_long_r;
    cpw_mode_t         mode_r;
    cpw_mode_t         mode_nxt;
    logic [CNT_W-1:0]  spi_cnt_r;
    logic [CNT_W-1:0]  acc_cnt_r;
    logic [CNT_W-1:0]  fwd_cnt_r;
    logic              spi_rdy_r;
    logic              acc_rdy_r;
    logic              fwd_pend_r;
    logic              wake_out_r;
    logic [SETTLE_W-1:0] settle_r;

    localparam logic [PULSE_W-1:0] RS_CYC = PULSE_W'(RST_PULSE_CYC);
    localparam logic [PULSE_W-1:0] RS_ONE = 8'h01;
    localparam logic [PULSE_W-1:0] RS_ZERO = 8'h00;
    localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(SYNC_SETTLE_CYC);
    localparam logic [SETTLE_W-1:0] SETTLE_ONE = SETTLE_W'(1);

    // A pin already high at reset must not look like a fresh rise
    wire settled   = (settle_r == SETTLE_END);

    wire vd_rise   = settled & i_is_master & vd_s & ~vd_d_r;
    // Reset pulse counts only once it ends, and only at least 100 ns long
    wire rs_fall   = rs_d_r & ~rst_s;
    wire rs_wake   = i_is_master & vd_s & rs_fall & rs_long_r;
    wire wk_rise   = settled & ~i_is_master & wk_s & ~wk_d_r;
    wire start     = vd_rise | rs_wake | wk_rise | i_sw_wake;
    wire supply_lo = i_is_master & ~vd_s;
    wire go_off    = supply_lo & ~i_pd_timer_run;
    wire powered   = (mode_r != CPW_MODE_FULL_PD);

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            CPW_MODE_FULL_PD: begin
                if (start) begin
                    mode_nxt = CPW_MODE_ACTIVE;
                end
            end
            CPW_MODE_ACTIVE: begin
                if (go_off) begin
                    mode_nxt = CPW_MODE_FULL_PD;
                end else if (i_sw_part_pd) begin
                    mode_nxt = CPW_MODE_PART_PD;
                end
            end
            CPW_MODE_PART_PD: begin
                if (go_off) begin
                    mode_nxt = CPW_MODE_FULL_PD;
                end else if (!i_sw_part_pd || start) begin
                    mode_nxt = CPW_MODE_ACTIVE;
                end
            end
            default: mode_nxt = CPW_MODE_FULL_PD;
        endcase
    end

    wire pw_start = start & (mode_r == CPW_MODE_FULL_PD);

    ////////////////////////////////////////////////////////////////////
    // Settle counter stops once the synchronisers reflect the pins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            settle_r <= '0;
        end else if (!settled) begin
            settle_r <= settle_r + SETTLE_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            vd_d_r    <= 1'b0;
            rs_d_r    <= 1'b0;
            wk_d_r    <= 1'b0;
            rs_len_r  <= RS_ZERO;
            rs_long_r <= 1'b0;
            mode_r    <= CPW_MODE_FULL_PD;
        end else begin
            vd_d_r <= vd_s;
            rs_d_r <= rst_s;
            wk_d_r <= wk_s;
            if (!rst_s) begin
                rs_len_r  <= RS_ZERO;
                rs_long_r <= 1'b0;
            end else if (rs_len_r < RS_CYC) begin
                rs_len_r  <= rs_len_r + RS_ONE;
                rs_long_r <= (rs_len_r + RS_ONE) >= RS_CYC;
            end
            mode_r <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Readiness timers restart on each power-up and clear on shutdown
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            spi_cnt_r <= CNT_ZERO;
            acc_cnt_r <= CNT_ZERO;
            spi_rdy_r <= 1'b0;
            acc_rdy_r <= 1'b0;
        end else if (!powered || go_off) begin
            spi_cnt_r <= CNT_ZERO;
            acc_cnt_r <= CNT_ZERO;
            spi_rdy_r <= 1'b0;
            acc_rdy_r <= 1'b0;
        end else if (!spi_rdy_r || !acc_rdy_r) begin
            spi_cnt_r <= spi_cnt_r + CNT_ONE;
            acc_cnt_r <= acc_cnt_r + CNT_ONE;
            if (spi_cnt_r == CNT_W'(SPI_CYC - 1)) begin
                spi_rdy_r <= 1'b1;
            end
            if (acc_cnt_r == CNT_W'(ACC_CYC - 1)) begin
                acc_rdy_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wake forward fires midway so it lands well inside the bound
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fwd_cnt_r  <= CNT_ZERO;
            fwd_pend_r <= 1'b0;
            wake_out_r <= 1'b0;
        end else if (go_off) begin
            fwd_cnt_r  <= CNT_ZERO;
            fwd_pend_r <= 1'b0;
            wake_out_r <= 1'b0;
        end else if (pw_start) begin
            fwd_cnt_r  <= CNT_W'(FWD_CYC / 2);
            fwd_pend_r <= 1'b1;
        end else if (fwd_pend_r) begin
            fwd_cnt_r <= dec_sat(fwd_cnt_r);
            if (fwd_cnt_r == CNT_ZERO) begin
                fwd_pend_r <= 1'b0;
                wake_out_r <= 1'b1;
            end
        end else if (!powered) begin
            wake_out_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign o_mode       = mode_r;
    assign o_spi_ready  = spi_rdy_r;
    assign o_conv_ready = acc_rdy_r;
    assign o_wake_out   = wake_out_r;
    // Conversions only when fully active and settled
    assign o_conv_en = (mode_r == CPW_MODE_ACTIVE) & acc_rdy_r;
    assign o_reg_en  = powered & spi_rdy_r;
    assign o_bal_en  = powered | (supply_lo & i_pd_timer_run);
endmodule : cpw_seq

// File: rtl/cpw_sync.sv
/*
 Three-stage pin synchroniser with agreement of stages two and three.
 Assumes the input is asynchronous to i_clk.
*/
`timescale 1ns/1ps
module cpw_sync (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // Pin
    input  wire logic i_pin,
    // Filtered level
    output logic      o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    wire  agree = (s2_r == s3_r);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree) begin
                lvl_r <= s3_r;
            end
        end
    end

    assign o_level = lvl_r;
endmodule : cpw_sync

// File: test/chain_power_mode_wakeup_test.sv
/* Self-checking bench for cpw_seq with short counts.
   Assumes cpw_far stands for the host and the device below. */
`timescale 1ns/1ps
module chain_power_mode_wakeup_test;
    import cpw_pkg::*;
    localparam int SPI = 20;
    localparam int ACC = 50;
    localparam int FWD = 10;
    logic i_clk, i_rst_b, i_is_master, i_sw_part_pd;
    logic i_sw_wake, i_pd_timer_run, vd, rp, wk;
    logic o_spi_ready, o_conv_ready, o_wake_out, o_conv_en, o_reg_en;
    logic o_bal_en;
    cpw_mode_t o_mode;
    int n_fail = 0, samples_checked = 0, m_mode, ts, tc, tw, k;
    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;
    cpw_far far (.i_clk(i_clk), .o_vdrive(vd), .o_reset_pin(rp),
        .o_wake_in(wk));
    cpw_seq #(.SPI_CYC(SPI), .ACC_CYC(ACC), .FWD_CYC(FWD)) dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_is_master(i_is_master),
        .i_vdrive(vd), .i_reset_pin(rp), .i_wake_in(wk),
        .i_sw_part_pd(i_sw_part_pd), .i_sw_wake(i_sw_wake),
        .i_pd_timer_run(i_pd_timer_run), .o_mode(o_mode),
        .o_spi_ready(o_spi_ready), .o_conv_ready(o_conv_ready),
        .o_wake_out(o_wake_out), .o_conv_en(o_conv_en),
        .o_reg_en(o_reg_en), .o_bal_en(o_bal_en));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", nm, e, s);
        end
    endtask : check
    task automatic conclude;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic idle(input int n, input int m);
        repeat (n) @(negedge i_clk);
        m_mode = m;
        check("mode", o_mode, m_mode);
    endtask : idle
    // Times each ready flag from the cycle the mode turns active
    task automatic time_up;
        ts = -1; tc = -1; tw = -1;
        for (k = 0; k < 12 && o_mode == CPW_MODE_FULL_PD; k++)
            @(negedge i_clk);
        idle(0, CPW_MODE_ACTIVE);
        for (k = 1; k <= ACC + 4; k++) begin
            @(negedge i_clk);
            if (o_spi_ready && ts < 0) ts = k;
            if (o_conv_ready && tc < 0) tc = k;
            if (o_wake_out && tw < 0) tw = k;
        end
        check("spi_time", ts >= SPI - 1 && ts <= SPI + 1, 1);
        check("conv_time", tc >= ACC - 1 && tc <= ACC + 1, 1);
        check("wake_time", tw > 0 && tw <= FWD, 1);
        check("conv_en", o_conv_en, 1);
        check("reg_en", o_reg_en, 1);
    endtask : time_up
    // Supply held high through reset, so no rising edge is seen
    task automatic rst(input logic ms);
        i_rst_b = 0;
        i_is_master = ms;
        far.supply(1);
        far.wake(0);
        repeat (4) @(negedge i_clk);
        i_rst_b = 1;
        idle(10, CPW_MODE_FULL_PD);
    endtask : rst
    initial begin
        #20000;
        n_fail++;
        conclude;
    end
    initial begin
        i_rst_b = 1'b0;
        i_is_master = 1'b1;
        i_sw_part_pd = 1'b0;
        i_sw_wake = 1'b0;
        i_pd_timer_run = 1'b0;
        k = $urandom(32'ha00e);
        idle(4, CPW_MODE_FULL_PD);
        i_rst_b = 1;
        idle(2, CPW_MODE_FULL_PD);
        check("spi_ready", o_spi_ready, 0);
        far.supply(1);
        time_up;
        i_sw_part_pd = 1;
        idle(3, CPW_MODE_PART_PD);
        check("conv_en_pp", o_conv_en, 0);
        check("reg_en_pp", o_reg_en, 1);
        check("bal_en_pp", o_bal_en, 1);
        i_sw_part_pd = 0;
        idle(3, CPW_MODE_ACTIVE);
        i_pd_timer_run = 1;
        far.supply(0);
        idle(8 + $urandom % 20, CPW_MODE_ACTIVE);
        check("bal_en_tmr", o_bal_en, 1);
        i_pd_timer_run = 0;
        idle(9, CPW_MODE_FULL_PD);
        check("spi_off", o_spi_ready, 0);
        rst(1);
        far.pulse(5);
        idle(10, CPW_MODE_FULL_PD);
        far.pulse(10 + $urandom % 8);
        time_up;
        rst(0);
        far.wake(1);
        time_up;
        far.supply(0);
        idle(12, CPW_MODE_ACTIVE);
        rst(1);
        i_sw_wake = 1;
        @(negedge i_clk);
        i_sw_wake = 0;
        idle(3, CPW_MODE_ACTIVE);
        conclude;
    end
endmodule : chain_power_mode_wakeup_test

// File: test/cpw_far.sv
/* Host and lower chain neighbour of the sequencer.
   Assumes callers start tasks near a falling clock edge. */
`timescale 1ns/1ps
module cpw_far (
    // Clock
    input  wire logic i_clk,
    // Pins
    output logic      o_vdrive,
    output logic      o_reset_pin,
    output logic      o_wake_in
);
    initial begin
        o_vdrive = 1'b0;
        o_reset_pin = 1'b0;
        o_wake_in = 1'b0;
    end
    task automatic supply(input logic on);
        @(negedge i_clk);
        o_vdrive = on;
        o_reset_pin = 1'b0;
    endtask : supply
    // Pulse only with supply up, since pins float otherwise
    task automatic pulse(input int n);
        @(negedge i_clk);
        o_reset_pin = o_vdrive;
        repeat (n) @(negedge i_clk);
        o_reset_pin = 1'b0;
    endtask : pulse
    task automatic wake(input logic v);
        @(negedge i_clk);
        o_wake_in = v;
    endtask : wake
endmodule : cpw_far

// File: test/cpw_seq_properties.sv
/* Port checker for the power sequencer.
   Bound into cpw_seq; its counts follow the bound parameters. */
`timescale 1ns/1ps
module cpw_seq_properties
    import cpw_pkg::*;
#(
    parameter int SPI_CYC = 20,
    parameter int ACC_CYC = 50,
    parameter int FWD_CYC = 10
) (
    // Watched ports
    input wire logic      i_clk,
    input wire logic      i_rst_b,
    input wire logic      i_is_master,
    input wire logic      i_vdrive,
    input wire logic      i_pd_timer_run,
    input wire cpw_mode_t o_mode,
    input wire logic      o_spi_ready,
    input wire logic      o_conv_ready,
    input wire logic      o_wake_out,
    input wire logic      o_conv_en,
    input wire logic      o_reg_en,
    input wire logic      o_bal_en
);
    localparam int S_LO = SPI_CYC - 2;
    localparam int S_HI = SPI_CYC + 2;
    localparam int A_LO = ACC_CYC - 2;
    localparam int A_HI = ACC_CYC + 2;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Straight from full power-down to active
    sequence s_up;
        $past(o_mode) == CPW_MODE_FULL_PD && o_mode == CPW_MODE_ACTIVE;
    endsequence
    // Six cycles so the pin synchroniser has settled
    sequence s_off;
        (i_is_master && !i_vdrive && !i_pd_timer_run) [*6];
    endsequence
    a_spi_ready_time: assert property (
        s_up |-> ##[S_LO:S_HI] o_spi_ready)
        else $error("serial ready late");
    a_conv_ready_time: assert property (
        s_up |-> ##[A_LO:A_HI] o_conv_ready)
        else $error("conversion ready late");
    a_wake_fwd_time: assert property (
        s_up |-> ##[1:FWD_CYC] o_wake_out)
        else $error("wake not forwarded");
    a_conv_en_gate: assert property (
        o_conv_en == (o_conv_ready && o_mode == CPW_MODE_ACTIVE))
        else $error("conversion permit wrong");
    a_reg_en_gate: assert property (
        o_reg_en == (o_spi_ready && o_mode != CPW_MODE_FULL_PD))
        else $error("register permit wrong");
    a_supply_off: assert property (
        s_off |-> ##[0:2] o_mode == CPW_MODE_FULL_PD)
        else $error("no power-down on supply loss");
    // A running timer seen at one edge keeps the next mode powered
    a_timer_defer: assert property (
        (i_pd_timer_run && o_mode != CPW_MODE_FULL_PD)
        |=> o_mode != CPW_MODE_FULL_PD)
        else $error("power-down while timer runs");
    a_powered_bal: assert property (
        o_mode != CPW_MODE_FULL_PD |-> o_bal_en)
        else $error("balancing lost while powered");
    a_mode_legal: assert property (
        o_mode inside {CPW_MODE_FULL_PD, CPW_MODE_ACTIVE,
                       CPW_MODE_PART_PD})
        else $error("illegal mode");
endmodule : cpw_seq_properties
bind cpw_seq cpw_seq_properties #(.SPI_CYC(SPI_CYC), .ACC_CYC(ACC_CYC),
    .FWD_CYC(FWD_CYC)) u_props (.*);
